// ### core/idf_dac_front.sv
// Notes on behaviour
// - Each input sample is captured on the rising edge of the 1x data clock at the clock pin.
// - The rate is raised fourfold by two cascaded halfband stages of 55 and 23 taps.
// - Inputs up to 32 MSPS are accepted and the converter updates at four times that rate.
// - The clock multiplier makes 1x and 4x ticks from the reference, once locked, or from the quad clock.
// - Charge pump on and oscillator select high enable the loop pump and oscillator.
// - The lock output goes high once the loop has locked to the reference.
// - With charge pump and oscillator select both low, the divider runs and, unless asleep, drives 1x or 2x out on the clock pin per range.
// - Devices fed by one reference update together and stay phase aligned.
// - Filter power save bypasses the interpolation filter to save digital power.
// - Sleep powers the device down and is held low when unused.
//
// Design decisions made here: register access over APB and the address map.
`default_nettype none
`include "idf_params.svh"

module idf_dac_front (
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic [13:0] i_sample,
    input  wire logic        i_ref_clock_in,
    output logic             o_ref_clock_out,
    output logic             o_ref_clock_oe,
    input  wire logic        i_quad_clock,
    output logic             o_loop_locked,
    output logic      [13:0] o_dac_code,
    output logic             o_dac_update
);

    idf_pkg::idf_top_st_t st;
    idf_pkg::idf_top_st_t next_st;
    idf_pkg::idf_mode_t   mode;
    logic                 is_loop;
    logic                 is_ext;
    logic                 ref_rise;
    logic                 q_fall;
    logic                 tick4;
    logic                 tick1;
    logic                 cap_now;
    logic                 pop_now;
    logic                 per_ok;
    logic                 per_near;
    logic [3:0]           per_diff;
    logic [4:0]           acc_step;
    logic                 addr_hit;
    logic                 wr;
    logic                 s1_valid;
    logic                 s1_ready;
    idf_pkg::idf_smp_t    ab_data;
    logic                 ab_valid;
    logic                 ab_ready;
    idf_pkg::idf_smp_t    s2_data;
    logic                 s2_valid;
    logic                 s2_ready;

    localparam logic [3:0] PER_FAST = 4'(`IDF_PER_FAST_MAX);
    localparam logic [3:0] PER_SLOW = 4'(`IDF_PER_SLOW_MAX);
    localparam logic [3:0] PER_MIN  = 4'(`IDF_PER_MIN);
    localparam logic [3:0] LOCK_N   = 4'(`IDF_LOCK_N);
    localparam logic [3:0] LOCK_TOL = 4'(`IDF_LOCK_TOL);

    // =================================================================
    // Interpolation chain
    idf_halfband #(
        .NU   (`IDF_NU_A),
        .COEF (idf_pkg::IDF_COEF_A)
    ) u_hb_a (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_data    (idf_pkg::idf_smp_t'(st.bq[0])),
        .i_valid   (s1_valid),
        .o_ready   (s1_ready),
        .o_data    (ab_data),
        .o_valid   (ab_valid),
        .i_ready   (ab_ready)
    );

    idf_halfband #(
        .NU   (`IDF_NU_B),
        .COEF (idf_pkg::IDF_COEF_B)
    ) u_hb_b (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_data    (ab_data),
        .i_valid   (ab_valid),
        .o_ready   (ab_ready),
        .o_data    (s2_data),
        .o_valid   (s2_valid),
        .i_ready   (s2_ready)
    );

    // =================================================================
    // Next state
    always_comb begin
        next_st  = st;
        tick4    = 1'b0;
        tick1    = 1'b0;
        if (st.ctrl.cp && st.ctrl.osc) begin
            mode = idf_pkg::IDF_MODE_LOOP;
        end else if (!st.ctrl.cp && !st.ctrl.osc) begin
            mode = idf_pkg::IDF_MODE_EXT;
        end else begin
            mode = idf_pkg::IDF_MODE_HOLD;
        end
        is_loop  = (mode == idf_pkg::IDF_MODE_LOOP);
        is_ext   = (mode == idf_pkg::IDF_MODE_EXT);
        // Only the second and third stages of each synchroniser are looked at
        ref_rise = st.ref_s2 && !st.ref_s3;
        q_fall   = st.q_s3 && !st.q_s2;
        next_st.ref_s1 = i_ref_clock_in;
        next_st.ref_s2 = st.ref_s1;
        next_st.ref_s3 = st.ref_s2;
        next_st.q_s1   = i_quad_clock;
        next_st.q_s2   = st.q_s1;
        next_st.q_s3   = st.q_s2;
        next_st.smp_s1 = i_sample;
        next_st.smp_s2 = st.smp_s1;
        acc_step = st.acc + 5'h04;
        per_diff = (st.cnt >= st.per) ? st.cnt - st.per : st.per - st.cnt;
        per_near = (per_diff <= LOCK_TOL);
        per_ok   = st.ctrl.lrs ? (st.cnt >= PER_FAST && st.cnt <= PER_SLOW)
                               : (st.cnt >= PER_MIN && st.cnt <= PER_FAST);
        next_st.oe = 1'b0;

        // Register writes; a clear of the overrun flag loses to a new one
        wr       = i_psel && i_penable && i_pwrite;
        addr_hit = (i_paddr == `IDF_OFF_CTRL) || (i_paddr == `IDF_OFF_STAT)
                || (i_paddr == `IDF_OFF_CODE);
        if (wr && i_paddr == `IDF_OFF_CTRL) begin
            next_st.ctrl = idf_pkg::idf_ctrl_t'(i_pwdata[`IDF_CTRL_W-1:0]);
        end
        if (wr && i_paddr == `IDF_OFF_STAT && i_pwdata[`IDF_STAT_OVR]) begin
            next_st.ovr = 1'b0;
        end
        if (i_psel && !i_penable) begin
            next_st.rdata = 32'h00000000;
            if (i_paddr == `IDF_OFF_CTRL) begin
                next_st.rdata[`IDF_CTRL_W-1:0] = st.ctrl;
            end else if (i_paddr == `IDF_OFF_STAT) begin
                next_st.rdata[`IDF_STAT_LOCK] = st.locked;
                next_st.rdata[`IDF_STAT_EXT]  = is_ext;
                next_st.rdata[`IDF_STAT_OVR]  = st.ovr;
            end else if (i_paddr == `IDF_OFF_CODE) begin
                next_st.rdata[`IDF_W-1:0] = st.dac;
            end
        end

        // Clock multiplier
        unique case (mode)
            idf_pkg::IDF_MODE_LOOP: begin
                if (ref_rise) begin
                    next_st.cnt = 4'h1;
                    next_st.per = st.cnt;
                    next_st.acc = 5'h00;
                    next_st.nq  = 2'h0;
                    if (per_ok && per_near) begin
                        if (st.match != LOCK_N) begin
                            next_st.match = st.match + 4'h1;
                        end
                    end else begin
                        next_st.match = 4'h0;
                    end
                    next_st.locked = (next_st.match == LOCK_N);
                    tick4 = st.locked;
                    tick1 = st.locked;
                end else if (st.cnt == 4'hF) begin
                    // Reference stopped: lock drops
                    next_st.match  = 4'h0;
                    next_st.locked = 1'b0;
                end else begin
                    next_st.cnt = st.cnt + 4'h1;
                    if (st.nq != 2'h3) begin
                        if (st.locked && acc_step >= {1'b0, st.per}) begin
                            tick4       = 1'b1;
                            next_st.acc = acc_step - {1'b0, st.per};
                            next_st.nq  = st.nq + 2'h1;
                        end else begin
                            next_st.acc = acc_step;
                        end
                    end
                end
            end
            idf_pkg::IDF_MODE_EXT: begin
                next_st.match  = 4'h0;
                next_st.locked = 1'b0;
                next_st.oe     = 1'b1;
                if (q_fall) begin
                    tick4       = 1'b1;
                    tick1       = (st.div == 2'h3);
                    next_st.div = st.div + 2'h1;
                end
                next_st.pin = st.ctrl.lrs ? !next_st.div[0] : !next_st.div[1];
            end
            default: begin
                next_st.match  = 4'h0;
                next_st.locked = 1'b0;
            end
        endcase
        if (st.ctrl.sleep) begin
            tick4          = 1'b0;
            tick1          = 1'b0;
            next_st.oe     = 1'b0;
            next_st.match  = 4'h0;
            next_st.locked = 1'b0;
        end
        next_st.t4 = tick4;
        next_st.t1 = tick1;

        // Two-entry input buffer; a stalled filter back-pressures it
        cap_now  = tick1;
        s1_valid = (st.bcnt != 2'h0) && !st.ctrl.sleep && !st.ctrl.fps;
        pop_now  = (st.bcnt != 2'h0) && !st.ctrl.sleep && (st.ctrl.fps || s1_ready);
        if (pop_now) begin
            next_st.bq[0] = st.bq[1];
            next_st.bcnt  = st.bcnt - 2'h1;
            if (st.ctrl.fps) begin
                next_st.held = st.bq[0];
            end
        end
        if (cap_now) begin
            if (next_st.bcnt == 2'h2) begin
                next_st.ovr = 1'b1;
            end else begin
                next_st.bq[next_st.bcnt[0]] = st.smp_s2;
                next_st.bcnt = next_st.bcnt + 2'h1;
            end
        end

        // Converter load once per 4x tick
        s2_ready    = st.t4 && !st.ctrl.sleep && !st.ctrl.fps;
        next_st.upd = 1'b0;
        if (st.t4 && !st.ctrl.sleep) begin
            if (st.ctrl.fps) begin
                next_st.dac = st.held;
                next_st.upd = 1'b1;
            end else if (s2_valid) begin
                next_st.dac = s2_data;
                next_st.upd = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st      <= '0;
            st.ctrl <= `IDF_CTRL_RST;
        end else begin
            st <= next_st;
        end
    end

    // =================================================================
    // Outputs
    assign o_prdata        = st.rdata;
    assign o_pready        = 1'b1;
    assign o_pslverr       = i_psel && i_penable && !addr_hit;
    assign o_ref_clock_out = st.pin;
    assign o_ref_clock_oe  = st.oe;
    assign o_loop_locked   = st.locked;
    assign o_dac_code      = st.dac;
    assign o_dac_update    = st.upd;

    // =================================================================
    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    a_capture_fills_buffer: assert property (
        (cap_now && !pop_now && st.bcnt == 2'h0)
        |=> (st.bcnt == 2'h1 && st.bq[0] == $past(st.smp_s2)))
        else $error("captured sample not placed in buffer");
    a_quad_to_single: assert property (
        ($past(is_ext) && st.t4) |-> (st.t1 == (st.div == 2'h0)))
        else $error("1x tick not every fourth 4x tick");
    a_pin_one_x: assert property (
        ($rose(o_ref_clock_out) && $past(o_ref_clock_oe) && !$past(st.ctrl.lrs)
         && !$past(st.ctrl.lrs, 2) && !$past(st.ctrl.sleep)) |-> st.t1)
        else $error("1x pin edge without capture tick");
    a_ext_drives_pin: assert property (
        ($past(i_resetn) && $past(is_ext && !st.ctrl.sleep)) |-> o_ref_clock_oe)
        else $error("divided clock not driven in quad-rate mode");
    a_lock_in_loop: assert property (
        o_loop_locked |-> $past(st.ctrl.cp && st.ctrl.osc))
        else $error("lock shown outside loop mode");
    a_lock_after_run: assert property (
        $rose(o_loop_locked) |-> ($past(st.match) == LOCK_N - 4'h1))
        else $error("lock raised before enough matching periods");
    a_ticks_on_ref: assert property (
        (is_loop && st.locked && ref_rise && !st.ctrl.sleep)
        |=> (st.t1 && st.t4 && st.acc == 5'h00))
        else $error("ticks not aligned to reference edge");
    a_ticks_need_enable: assert property (
        (st.t4 && !$past(is_ext)) |-> $past(st.ctrl.cp && st.ctrl.osc))
        else $error("loop ticks without both enables");
    a_sleep_freezes: assert property (
        st.ctrl.sleep |=> (!o_dac_update && $stable(o_dac_code)))
        else $error("converter changed while asleep");
    a_filter_power_save_holds: assert property (
        (st.ctrl.fps && !st.ctrl.sleep && st.t4)
        |=> (o_dac_update && o_dac_code == $past(st.held)))
        else $error("bypass did not load held sample");
    a_dac_on_tick: assert property (
        o_dac_update |-> $past(st.t4))
        else $error("converter load without 4x tick");

    c_lock: cover property ($rose(o_loop_locked));
    c_ext_capture: cover property (is_ext && st.t1);
    c_filter_power_save_load: cover property (st.ctrl.fps && o_dac_update);
    c_overrun: cover property ($rose(st.ovr));

endmodule

`default_nettype wire

// ### core/idf_halfband.sv
`default_nettype none

module idf_halfband #(
    parameter int               NU   = 6,
    parameter logic [NU-1:0][15:0] COEF = '0
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_resetn,
    input  wire idf_pkg::idf_smp_t i_data,
    input  wire logic              i_valid,
    output logic                   o_ready,
    output idf_pkg::idf_smp_t      o_data,
    output logic                   o_valid,
    input  wire logic              i_ready
);

    typedef struct packed {
        logic [2*NU-1:0][13:0] hist;
        logic                  full;
        logic                  ph;
    } idf_hb_st_t;

    idf_hb_st_t         st;
    idf_hb_st_t         next_st;
    logic signed [39:0] acc;
    logic signed [39:0] pair;

    // =================================================================
    // Two outputs per input: interpolated midpoint, then centre sample
    always_comb begin
        next_st = st;
        acc     = '0;
        pair    = '0;
        for (int k = 0; k < NU; k++) begin
            pair = 40'($signed(st.hist[NU-1-k])) + 40'($signed(st.hist[NU+k]));
            acc  = acc + pair * 40'($signed(COEF[k]));
        end
        o_valid = st.full;
        o_ready = !st.full || (st.ph && i_ready);
        o_data  = st.ph ? idf_pkg::idf_smp_t'(st.hist[NU-1]) : idf_pkg::idf_rnd_sat(acc);
        if (st.full && i_ready) begin
            if (!st.ph) begin
                next_st.ph = 1'b1;
            end else begin
                next_st.full = 1'b0;
            end
        end
        if (i_valid && o_ready) begin
            next_st.hist = {st.hist[2*NU-2:0], i_data};
            next_st.full = 1'b1;
            next_st.ph   = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // =================================================================
    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    a_stage_two_out: assert property (
        (i_valid && o_ready) |=> (o_valid && !st.ph && st.hist[0] == $past(i_data)))
        else $error("stage did not present first output after accept");
    a_stage_centre: assert property (
        (o_valid && !st.ph && i_ready) |=> (o_valid && o_data == $past(st.hist[NU-1])))
        else $error("stage second output is not the centre sample");

endmodule

`default_nettype wire

// ### pkg/idf_params.svh
`ifndef IDF_PARAMS_SVH
`define IDF_PARAMS_SVH

// =====================================================================
// Clock and reference ranges
`define IDF_SYS_HZ        40000000
`define IDF_FAST_REF_HZ   10000000
`define IDF_SLOW_REF_HZ   5500000
// Longest periods round down to whole system cycles
`define IDF_PER_FAST_MAX  (`IDF_SYS_HZ / `IDF_FAST_REF_HZ)
`define IDF_PER_SLOW_MAX  (`IDF_SYS_HZ / `IDF_SLOW_REF_HZ)
`define IDF_PER_MIN       2
`define IDF_LOCK_N        8
`define IDF_LOCK_TOL      1

// =====================================================================
// Data path
`define IDF_W             14
`define IDF_TAPS_A        55
`define IDF_TAPS_B        23
`define IDF_NU_A          ((`IDF_TAPS_A + 1) / 4)
`define IDF_NU_B          ((`IDF_TAPS_B + 1) / 4)

// =====================================================================
// Register map
`define IDF_OFF_CTRL      12'h000
`define IDF_OFF_STAT      12'h004
`define IDF_OFF_CODE      12'h008
`define IDF_CTRL_W        5
`define IDF_CTRL_RST      5'h00
`define IDF_STAT_LOCK     0
`define IDF_STAT_EXT      1
`define IDF_STAT_OVR      2

`endif

// ### pkg/idf_pkg.sv
`default_nettype none
`include "idf_params.svh"

package idf_pkg;

    // =================================================================
    // Types
    typedef logic signed [`IDF_W-1:0] idf_smp_t;

    typedef enum logic [1:0] {
        IDF_MODE_EXT  = 2'b00,
        IDF_MODE_LOOP = 2'b01,
        IDF_MODE_HOLD = 2'b10
    } idf_mode_t;

    typedef struct packed {
        logic sleep;
        logic fps;
        logic lrs;
        logic osc;
        logic cp;
    } idf_ctrl_t;

    typedef struct packed {
        idf_ctrl_t              ctrl;
        logic                   ovr;
        logic                   ref_s1;
        logic                   ref_s2;
        logic                   ref_s3;
        logic                   q_s1;
        logic                   q_s2;
        logic                   q_s3;
        logic [`IDF_W-1:0]      smp_s1;
        logic [`IDF_W-1:0]      smp_s2;
        logic [3:0]             cnt;
        logic [3:0]             per;
        logic [4:0]             acc;
        logic [1:0]             nq;
        logic [3:0]             match;
        logic                   locked;
        logic [1:0]             div;
        logic                   pin;
        logic                   oe;
        logic                   t4;
        logic                   t1;
        logic [1:0][`IDF_W-1:0] bq;
        logic [1:0]             bcnt;
        logic [`IDF_W-1:0]      held;
        logic [`IDF_W-1:0]      dac;
        logic                   upd;
        logic [31:0]            rdata;
    } idf_top_st_t;

    // Q15 coefficients, nearest to centre listed last (index 0); values arbitrary, unity gain
    localparam logic [13:0][15:0] IDF_COEF_A = {
        16'hFFC4, 16'h006E, 16'hFF4C, 16'h010E, 16'hFE7A, 16'h021C, 16'hFD1C,
        16'h03E8, 16'hFABA, 16'h073A, 16'hF5D8, 16'h0F3C, 16'hE570, 16'h5162};
    localparam logic [5:0][15:0] IDF_COEF_B = {
        16'hFF28, 16'h0190, 16'hFC18, 16'h0898, 16'hEC78, 16'h4E20};

    // Round Q15 to nearest, clamp so codes never wrap
    function automatic idf_smp_t idf_rnd_sat(input logic signed [39:0] a);
        logic signed [39:0] r;
        r = (a + 40'sh0000004000) >>> 15;
        if (r > 40'sh0000001FFF) begin
            return 14'h1FFF;
        end else if (r < 40'shFFFFFFE000) begin
            return 14'h2000;
        end
        return r[13:0];
    endfunction

endpackage

`default_nettype wire

// ### tb/idf_src_model.sv
`default_nettype none

module idf_src_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_loop,
    input  wire logic        i_run,
    input  wire logic [13:0] i_value,
    output logic             o_ref,
    output logic             o_ref_en,
    output logic             o_quad,
    output logic      [13:0] o_sample
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [2:0] cnt;

    // =================================================================
    // Upstream source: reference period 6, quad period 4
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt      <= 3'h0;
            o_ref    <= 1'b0;
            o_ref_en <= 1'b0;
            o_quad   <= 1'b0;
            o_sample <= 14'h0000;
        end else begin
            cnt      <= (cnt == 3'h5 || (!i_loop && cnt == 3'h3)) ? 3'h0 : cnt + 3'h1;
            o_ref_en <= i_loop;
            // Released pin toggles so a stale level never looks valid
            o_ref    <= i_loop ? (i_run && cnt < 3'h3) : ~o_ref;
            // Quad clock stands still outside ext mode
            o_quad   <= i_run && !i_loop && cnt < 3'h2;
            // In loop mode data changes well after the rising edge; in ext mode it follows i_value every cycle
            if (!i_loop || cnt == 3'h4) begin
                o_sample <= i_value;
            end
        end
    end

endmodule

`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic        wr;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] r;
        logic        e;
    } idf_tb_row_t;

    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        src_loop = 1'b0;
    logic        src_run = 1'b0;
    logic [13:0] src_val = 14'h0000;
    logic [13:0] smp;
    logic        s_ref;
    logic        s_en;
    logic        quad;
    logic        pin_out;
    logic        pin_oe;
    logic        pin;
    logic        pin_q = 1'b0;
    logic        locked;
    logic [13:0] code;
    logic        upd;
    int          miscompares = 0;
    int          checked = 0;
    int          n_rise = 0;
    int          n_upd = 0;
    int          n_clash = 0;
    int          r;
    int          u;
    logic [31:0] rd;
    logic        er;
    idf_tb_row_t rows [8] = '{
        '{1'h1, 12'h000, 32'h0000001F, 32'h0, 1'h0},
        '{1'h0, 12'h000, 32'h0, 32'h0000001F, 1'h0},
        '{1'h1, 12'h000, 32'hFFFFFFE4, 32'h0, 1'h0},
        '{1'h0, 12'h000, 32'h0, 32'h00000004, 1'h0},
        '{1'h0, 12'h00C, 32'h0, 32'h0, 1'h1},
        '{1'h1, 12'hFFC, 32'h00000001, 32'h0, 1'h1},
        '{1'h0, 12'h000, 32'h0, 32'h00000004, 1'h0},
        '{1'h1, 12'h000, 32'h0, 32'h0, 1'h0}};

    always #12.5 clk = ~clk;

    // Either party may own the clock pin
    assign pin = pin_oe ? pin_out : s_ref;

    always @(posedge clk) begin
        pin_q <= pin;
        if (pin && !pin_q) n_rise <= n_rise + 1;
        if (upd === 1'b1) n_upd <= n_upd + 1;
        if (pin_oe === 1'b1 && s_en === 1'b1) n_clash <= n_clash + 1;
    end

    idf_src_model i_src (.i_clk_sys(clk), .i_resetn(rstn), .i_loop(src_loop),
        .i_run(src_run), .i_value(src_val), .o_ref(s_ref), .o_ref_en(s_en),
        .o_quad(quad), .o_sample(smp));

    idf_dac_front i_dut (.i_clk_sys(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_sample(smp), .i_ref_clock_in(pin),
        .o_ref_clock_out(pin_out), .o_ref_clock_oe(pin_oe), .i_quad_clock(quad),
        .o_loop_locked(locked), .o_dac_code(code), .o_dac_update(upd));

    // =================================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic measure(input int n);
        int r0;
        int u0;
        r0 = n_rise;
        u0 = n_upd;
        repeat (n) @(posedge clk);
        r = n_rise - r0;
        u = n_upd - u0;
    endtask

    task automatic near(input int x, input int e, input int tol);
        check({31'h0, (x - e <= tol) && (e - x <= tol)}, 32'h1);
    endtask

    task automatic final_report();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // =================================================================
    // Watchdog: the whole sequence needs well under 10000 cycles
    initial begin
        #(25 * 40000);
        miscompares++;
        final_report();
    end

    initial begin
        repeat (10) @(posedge clk);
        check({pready, pin_oe, locked, upd, code}, {4'h8, 14'h0000});
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            check({31'h0, er}, {31'h0, rows[i].e});
            if (!rows[i].wr) check(rd, rows[i].r);
        end
        // Ext quad-rate mode, divider drives 1x then 2x
        src_run <= 1'b1;
        repeat (400) @(posedge clk);
        check({31'h0, pin_oe}, 32'h1);
        check({18'h0, code}, 32'h0);
        measure(256);
        near(r, 16, 1);
        near(u, 64, 2);
        apb(1'b1, 12'h000, 32'h4);
        repeat (20) @(posedge clk);
        measure(256);
        near(r, 32, 1);
        apb(1'b0, 12'h004, 32'h0);
        check(rd & 32'h3, 32'h2);
        // Filter bypass holds the sample
        src_val <= 14'h1234;
        apb(1'b1, 12'h000, 32'h8);
        repeat (200) @(posedge clk);
        check({18'h0, code}, 32'h1234);
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h1234);
        // Full-scale inputs through filters must not wrap
        src_val <= 14'h1FFF;
        apb(1'b1, 12'h000, 32'h0);
        repeat (600) @(posedge clk);
        check({31'h0, code[13]}, 32'h0);
        src_val <= 14'h2000;
        repeat (600) @(posedge clk);
        check({31'h0, code[13]}, 32'h1);
        // Loop mode, reference in the 5.5 to 10 MHz range
        src_val <= 14'h0ABC;
        apb(1'b1, 12'h000, 32'hF);
        // Take the pin only once the divider has let go of it
        src_loop <= 1'b1;
        for (int k = 0; k < 500 && locked !== 1'b1; k++) @(posedge clk);
        check({31'h0, locked}, 32'h1);
        repeat (100) @(posedge clk);
        measure(240);
        near(u, 160, 2);
        check({18'h0, code}, 32'h0ABC);
        apb(1'b0, 12'h004, 32'h0);
        check(rd & 32'h3, 32'h1);
        // Mixed enables give no ticks and no lock
        apb(1'b1, 12'h000, 32'h5);
        repeat (100) @(posedge clk);
        check({31'h0, locked}, 32'h0);
        measure(100);
        near(u, 0, 0);
        // Sleep in ext mode releases the pin and stops updates
        src_loop <= 1'b0;
        apb(1'b1, 12'h000, 32'h10);
        repeat (60) @(posedge clk);
        check({31'h0, pin_oe}, 32'h0);
        measure(100);
        near(u, 0, 0);
        apb(1'b1, 12'h000, 32'h0);
        repeat (60) @(posedge clk);
        check({31'h0, pin_oe}, 32'h1);
        near(n_clash, 0, 0);
        final_report();
    end

endmodule

`default_nettype wire
